// ---- rtl/ptu_pkg.sv ----
/*
  Package for the periodic tick unit: register map, control field layout,
  bus response codes, divider tap table, bus carriers and the state record.
  Assumes a 32-bit AXI4-Lite register bus and an 8-bit control register.
*/
package ptu_pkg;

  // Widths
  localparam int unsigned PTU_ADDR_W = 8;
  localparam int unsigned PTU_DATA_W = 32;
  localparam int unsigned PTU_CNT_W  = 15;
  localparam int unsigned PTU_EVT_W  = 2;

  // Register byte addresses
  localparam logic [PTU_ADDR_W-1:0] PTU_OFS_CTL  = 8'h1c;
  localparam logic [PTU_ADDR_W-1:0] PTU_OFS_STS  = 8'h20;
  localparam logic [PTU_ADDR_W-1:0] PTU_OFS_MASK = 8'h24;

  // Control register field positions
  localparam int unsigned PTU_BIT_EN   = 1;
  localparam int unsigned PTU_BIT_IE   = 2;
  localparam int unsigned PTU_BIT_ACK  = 3;
  localparam int unsigned PTU_RATE_LSB = 4;
  localparam int unsigned PTU_BIT_PEND = 7;

  // Event status bit positions
  localparam int unsigned PTU_EVT_TICK  = 0;
  localparam int unsigned PTU_EVT_BLOCK = 1;

  // Bus responses
  localparam logic [1:0] PTU_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PTU_RESP_SLVERR = 2'h2;
  localparam logic [1:0] PTU_RESP_DECERR = 2'h3;

  // Divider bit whose rise marks an event: period is twice its weight
  localparam logic [3:0] PTU_TAP_IDX [0:7] = '{4'he, 4'hc, 4'ha, 4'h6,
                                               4'h5, 4'h4, 4'h3, 4'h2};

  // Bus carriers, master to slave
  typedef struct packed {
    logic                  awvalid;
    logic [PTU_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [PTU_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [PTU_ADDR_W-1:0] araddr;
    logic                  rready;
  } ptu_axi_req_t;

  // Bus carriers, slave to master
  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [PTU_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
  } ptu_axi_rsp_t;

  // Whole state of the unit
  typedef struct packed {
    logic                  osc_q;
    logic [PTU_CNT_W-1:0]  cnt;
    logic                  en;
    logic                  ie;
    logic [2:0]            rate;
    logic                  pend;
    logic [PTU_EVT_W-1:0]  sts;
    logic [PTU_EVT_W-1:0]  msk;
    logic                  irq;
    logic                  tick_irq;
    logic                  wake;
    logic                  aw_have;
    logic [PTU_ADDR_W-1:0] awaddr;
    logic                  w_have;
    logic [PTU_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    ptu_axi_rsp_t          bus;
  } ptu_state_t;

  localparam ptu_state_t PTU_STATE_RST = '{
    bus: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    default: '0
  };

endpackage

// ---- rtl/ptu_periodic_tick.sv ----
/*
  Periodic tick unit: a divider chain stepped by edges of the crystal
  oscillator clock, a pending flag set at a selectable tap, an interrupt
  request, a stop-mode wake request, and an AXI4-Lite register slave.
  Assumes all inputs, the oscillator clock among them, are synchronous to
  clk_sys, and that the oscillator runs at no more than half of clk_sys.
*/
`timescale 1ns/1ns

module ptu_periodic_tick (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          crystal_osc_clock,
  input  wire logic          wait_mode,
  input  wire logic          stop_mode,
  input  wire logic          osc_run_in_stop,
  input  wire ptu_pkg::ptu_axi_req_t axi_req,
  output      ptu_pkg::ptu_axi_rsp_t axi_rsp,
  output logic               tick_irq,
  output logic               irq,
  output logic               stop_wake
);
  import ptu_pkg::*;

  ptu_state_t            st_r;
  ptu_state_t            st_nxt;
  logic                  osc_rise;
  logic                  lp_block;
  logic                  cnt_live;
  logic                  wr_fire;
  logic                  wr_ok;
  logic                  ack_wr;
  logic                  tick_evt;
  logic                  rd_fire;
  logic                  blk_evt;
  logic [3:0]            tap;
  logic [PTU_CNT_W-1:0]  cnt_inc;
  logic [PTU_CNT_W-1:0]  low_mask;
  logic [PTU_EVT_W-1:0]  sts_set;
  logic [PTU_EVT_W-1:0]  sts_clr;

  // Outputs taken straight from the state flops
  assign axi_rsp   = st_r.bus;
  assign tick_irq  = st_r.tick_irq;
  assign irq       = st_r.irq;
  assign stop_wake = st_r.wake;

  // Next-state logic for the whole unit
  always_comb begin
    st_nxt   = st_r;
    sts_set  = '0;
    sts_clr  = '0;
    blk_evt  = 1'b0;
    ack_wr   = 1'b0;

    // Edge of the oscillator clock and the power-mode view
    osc_rise     = crystal_osc_clock & ~st_r.osc_q;
    st_nxt.osc_q = crystal_osc_clock;
    lp_block     = wait_mode | stop_mode;
    cnt_live     = ~stop_mode | osc_run_in_stop;

    // Write address and write data are taken in either order
    if (axi_req.awvalid && st_r.bus.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_r.bus.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = axi_req.wdata;
      st_nxt.wstrb  = axi_req.wstrb;
    end

    // Write is carried out one cycle after both halves are held
    wr_fire = st_r.aw_have && st_r.w_have && !st_r.bus.bvalid;
    wr_ok   = wr_fire && !lp_block && st_r.wstrb[0];
    if (st_r.bus.bvalid && axi_req.bready) begin
      st_nxt.bus.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_nxt.aw_have    = 1'b0;
      st_nxt.w_have     = 1'b0;
      st_nxt.bus.bvalid = 1'b1;
      st_nxt.bus.bresp  = PTU_RESP_OKAY;
      unique case (st_r.awaddr)
        PTU_OFS_CTL: begin
          if (lp_block) begin
            st_nxt.bus.bresp = PTU_RESP_SLVERR;
            blk_evt          = 1'b1;
          end else if (wr_ok) begin
            st_nxt.en   = st_r.wdata[PTU_BIT_EN];
            st_nxt.ie   = st_r.wdata[PTU_BIT_IE];
            st_nxt.rate = st_r.wdata[PTU_RATE_LSB +: 3];
            ack_wr      = st_r.wdata[PTU_BIT_ACK];
          end
        end
        PTU_OFS_STS: begin
          if (st_r.wstrb[0]) begin
            sts_clr = st_r.wdata[PTU_EVT_W-1:0];
          end
        end
        PTU_OFS_MASK: begin
          if (st_r.wstrb[0]) begin
            st_nxt.msk = st_r.wdata[PTU_EVT_W-1:0];
          end
        end
        default: begin
          st_nxt.bus.bresp = PTU_RESP_DECERR;
        end
      endcase
    end
    st_nxt.bus.awready = !st_nxt.aw_have && !st_nxt.bus.bvalid;
    st_nxt.bus.wready  = !st_nxt.w_have && !st_nxt.bus.bvalid;

    // Read channel: one read at a time, answer one cycle after the address
    rd_fire = axi_req.arvalid && st_r.bus.arready;
    if (st_r.bus.rvalid && axi_req.rready) begin
      st_nxt.bus.rvalid  = 1'b0;
      st_nxt.bus.arready = 1'b1;
    end
    if (rd_fire) begin
      st_nxt.bus.arready = 1'b0;
      st_nxt.bus.rvalid  = 1'b1;
      st_nxt.bus.rdata   = '0;
      st_nxt.bus.rresp   = PTU_RESP_OKAY;
      unique case (axi_req.araddr)
        PTU_OFS_CTL: begin
          if (lp_block) begin
            st_nxt.bus.rresp = PTU_RESP_SLVERR;
            blk_evt          = 1'b1;
          end else begin
            st_nxt.bus.rdata[PTU_BIT_EN]          = st_r.en;
            st_nxt.bus.rdata[PTU_BIT_IE]          = st_r.ie;
            st_nxt.bus.rdata[PTU_BIT_ACK]         = 1'b0;
            st_nxt.bus.rdata[PTU_RATE_LSB +: 3]   = st_r.rate;
            st_nxt.bus.rdata[PTU_BIT_PEND]        = st_r.pend;
          end
        end
        PTU_OFS_STS: begin
          st_nxt.bus.rdata[PTU_EVT_W-1:0] = st_r.sts;
        end
        PTU_OFS_MASK: begin
          st_nxt.bus.rdata[PTU_EVT_W-1:0] = st_r.msk;
        end
        default: begin
          st_nxt.bus.rresp = PTU_RESP_DECERR;
        end
      endcase
    end

    // Divider chain: cleared while disabled, steps on oscillator edges
    tap      = PTU_TAP_IDX[st_r.rate];
    cnt_inc  = st_r.cnt + PTU_CNT_W'(1);
    low_mask = (PTU_CNT_W'(1) << tap) - PTU_CNT_W'(1);
    tick_evt = 1'b0;
    if (!st_nxt.en) begin
      st_nxt.cnt = '0;
    end else if (st_r.en && osc_rise && cnt_live) begin
      st_nxt.cnt = cnt_inc;
      // Tap bit rising: half period after start, full period after that
      tick_evt   = !st_r.cnt[tap] && cnt_inc[tap];
    end

    // Pending flag: an overflow in the acknowledge cycle wins
    if (ack_wr) begin
      st_nxt.pend = 1'b0;
    end
    if (tick_evt) begin
      st_nxt.pend = 1'b1;
    end

    // Sticky event status, write one to clear, set wins over clear
    sts_set[PTU_EVT_TICK]  = tick_evt;
    sts_set[PTU_EVT_BLOCK] = blk_evt;
    st_nxt.sts = (st_r.sts & ~sts_clr) | sts_set;

    // Request outputs
    st_nxt.tick_irq = st_nxt.pend & st_nxt.ie;
    st_nxt.irq      = |(st_nxt.sts & st_nxt.msk);
    st_nxt.wake     = stop_mode & cnt_live & st_nxt.pend & st_nxt.ie;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= PTU_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Checks on the unit's own behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_ack_write;
    wr_ok && (st_r.awaddr == PTU_OFS_CTL) && st_r.wdata[PTU_BIT_ACK];
  endsequence

  sequence s_osc_step;
    st_r.en && st_nxt.en && osc_rise && cnt_live;
  endsequence

  a_hold_zero: assert property (
    !st_r.en |-> (st_r.cnt == '0))
    else $error("divider not zero while disabled");

  a_count_step: assert property (
    s_osc_step |=> (st_r.cnt == $past(st_r.cnt) + PTU_CNT_W'(1)))
    else $error("divider did not step on oscillator edge");

  a_tick_sets: assert property (
    tick_evt |=> st_r.pend [*1] ##1 (st_r.pend || $past(ack_wr)))
    else $error("tap overflow did not set pending");

  a_irq_level: assert property (
    (st_r.pend && st_r.ie) ##1 (st_r.pend && st_r.ie) |-> tick_irq)
    else $error("interrupt request missing");

  a_ack_clears: assert property (
    (s_ack_write and !tick_evt) |=> !st_r.pend && !tick_irq)
    else $error("acknowledge did not clear pending");

  a_ack_reads: assert property (
    rd_fire && (axi_req.araddr == PTU_OFS_CTL) |=> !axi_rsp.rdata[PTU_BIT_ACK])
    else $error("acknowledge bit read as one");

  a_tap_phase: assert property (
    tick_evt |-> st_nxt.cnt[tap] && ((st_nxt.cnt & low_mask) == '0))
    else $error("event off the selected tap");

  a_rate_tap: assert property (
    tick_evt && (st_r.rate == 3'h0) |-> (st_nxt.cnt == 15'h4000))
    else $error("slowest rate event at wrong count");

  a_reset_clear: assert property (
    $fell(rst) |-> !st_r.en && !st_r.ie && (st_r.cnt == '0))
    else $error("reset left the divider enabled");

  a_access_block: assert property (
    wr_fire && lp_block && (st_r.awaddr == PTU_OFS_CTL)
      |=> $stable(st_r.en) && $stable(st_r.rate) && (axi_rsp.bresp == PTU_RESP_SLVERR))
    else $error("register written in low-power mode");

  a_stop_freeze: assert property (
    stop_mode && !osc_run_in_stop |=> $stable(st_r.cnt) or !st_r.en)
    else $error("divider ran in stop without oscillator");

  a_stop_wake: assert property (
    stop_mode && osc_run_in_stop && st_r.pend && st_r.ie ##1 stop_mode |-> stop_wake)
    else $error("no wake request in stop");

  a_read_block: assert property (
    rd_fire && stop_mode && (axi_req.araddr == PTU_OFS_CTL)
      |=> axi_rsp.rvalid && (axi_rsp.rdata == '0) && (axi_rsp.rresp == PTU_RESP_SLVERR))
    else $error("register read in stop mode");

  a_set_wins: assert property (
    (s_ack_write and tick_evt) |=> st_r.pend)
    else $error("event lost against acknowledge");

  // Bus handshake checks
  sequence s_write_apply;
    st_r.aw_have && st_r.w_have && !axi_rsp.bvalid;
  endsequence

  sequence s_resp_stall;
    axi_rsp.bvalid && !axi_req.bready;
  endsequence

  sequence s_read_stall;
    axi_rsp.rvalid && !axi_req.rready;
  endsequence

  a_write_answer: assert property (
    s_write_apply |=> axi_rsp.bvalid)
    else $error("write response missing");

  a_write_once: assert property (
    s_write_apply |=> !st_r.aw_have && !st_r.w_have)
    else $error("write halves not released");

  a_bresp_hold: assert property (
    s_resp_stall |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before bready");

  a_write_busy: assert property (
    axi_rsp.bvalid
      |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write accepted while response pending");

  a_read_answer: assert property (
    rd_fire |=> axi_rsp.rvalid)
    else $error("read response missing");

  a_rdata_hold: assert property (
    s_read_stall
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read response dropped before rready");

  a_read_busy: assert property (
    axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read accepted while response pending");

  // Event status and interrupt checks
  a_event_irq: assert property (
    irq == |(st_r.sts & st_r.msk))
    else $error("event interrupt does not follow status and mask");

  a_status_set: assert property (
    tick_evt |=> st_r.sts[PTU_EVT_TICK])
    else $error("tick event not recorded");

  a_status_sticky: assert property (
    st_r.sts[PTU_EVT_TICK] && !sts_clr[PTU_EVT_TICK]
      |=> st_r.sts[PTU_EVT_TICK])
    else $error("tick status lost without a clear");

  a_block_status: assert property (
    blk_evt |=> st_r.sts[PTU_EVT_BLOCK])
    else $error("refused access not recorded");

  a_irq_off: assert property (
    !st_r.ie |-> !tick_irq)
    else $error("interrupt request with interrupt disabled");

  // Pending flag, divider and power-mode checks
  a_pend_keeps: assert property (
    st_r.pend && !ack_wr |=> st_r.pend)
    else $error("pending cleared without acknowledge");

  a_pend_source: assert property (
    !st_r.pend && !tick_evt |=> !st_r.pend)
    else $error("pending set without tap event");

  a_disable_zero: assert property (
    wr_ok && (st_r.awaddr == PTU_OFS_CTL) && !st_r.wdata[PTU_BIT_EN]
      |=> (st_r.cnt == '0))
    else $error("disable did not clear the divider");

  a_rate_fast: assert property (
    tick_evt && (st_r.rate == 3'h7)
      |-> (st_nxt.cnt[2:0] == 3'h4))
    else $error("fastest rate event at wrong count");

  a_wait_runs: assert property (
    wait_mode && !stop_mode && st_r.en && st_nxt.en && osc_rise
      |=> (st_r.cnt == $past(st_r.cnt) + PTU_CNT_W'(1)))
    else $error("divider stalled in wait mode");

  a_blocked_ie: assert property (
    wr_fire && lp_block && (st_r.awaddr == PTU_OFS_CTL)
      |=> $stable(st_r.ie))
    else $error("interrupt enable written in low-power mode");

  a_wake_stop: assert property (
    !stop_mode |=> !stop_wake)
    else $error("wake request outside stop mode");

  a_wake_gate: assert property (
    stop_mode && !osc_run_in_stop |=> !stop_wake)
    else $error("wake request with oscillator stopped");

endmodule // ptu_periodic_tick

// ---- verif/tb.sv ----
/*
  Self-checking bench for the periodic tick unit: register access over
  AXI4-Lite, tick timing for rates 2 to 7, event interrupt, low-power refusals.
  Assumes ptu_pkg and ptu_periodic_tick are compiled before this file.
*/
`timescale 1ns/1ns

module tb;
  import ptu_pkg::*;

  localparam int PER [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

  logic         clk_sys = 1'b0;
  logic         rst;
  logic         osc = 1'b0;
  logic         wait_mode;
  logic         stop_mode;
  logic         osc_run;
  ptu_axi_req_t req;
  ptu_axi_rsp_t rsp;
  logic         tick_irq;
  logic         irq;
  logic         stop_wake;
  logic         irq_q = 1'b0;
  logic [31:0]  cfg;
  int           osc_cnt = 0;
  int           stamp = 0;
  int           nrise = 0;
  int           t0;
  int           n0;
  int           s1;
  int           err_total;
  int           compares;

  ptu_periodic_tick i_ptu_periodic_tick (
    .clk_sys(clk_sys), .rst(rst), .crystal_osc_clock(osc), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .osc_run_in_stop(osc_run), .axi_req(req), .axi_rsp(rsp),
    .tick_irq(tick_irq), .irq(irq), .stop_wake(stop_wake));

  // System clock, 20 ns period
  always #10 clk_sys = ~clk_sys;

  // Crystal stand-in running free, counting its own rises
  always @(posedge clk_sys) begin
    osc <= ~osc;
    if (osc === 1'b0) osc_cnt <= osc_cnt + 1;
  end

  // Oscillator count captured at each rise of tick_irq
  always @(posedge clk_sys) begin
    irq_q <= tick_irq;
    if (tick_irq === 1'b1 && irq_q !== 1'b1) begin
      stamp <= osc_cnt;
      nrise <= nrise + 1;
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One write; handshakes judged from values settled at the falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, hb;
    logic [1:0] r;
    int n;
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    hb = 1'b0;
    n = 0;
    while (!hb && n < 100) begin
      @(negedge clk_sys);
      ta = req.awvalid & rsp.awready;
      tw = req.wvalid & rsp.wready;
      hb = (rsp.bvalid === 1'b1);
      r = rsp.bresp;
      n++;
      @(posedge clk_sys);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    chk("bvalid", {31'h0, hb}, 32'h1);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask

  // One read, data compared under a mask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, hr;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    hr = 1'b0;
    n = 0;
    while (!hr && n < 100) begin
      @(negedge clk_sys);
      ta = req.arvalid & rsp.arready;
      hr = (rsp.rvalid === 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
      n++;
      @(posedge clk_sys);
      if (ta) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    chk("rvalid", {31'h0, hr}, 32'h1);
    chk("rdata", d & m, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask

  // Bounded wait for a further rise of tick_irq
  task automatic wait_rise(input int k);
    int n;
    n = 0;
    while (nrise <= k && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("tick_rise", {31'h0, nrise > k}, 32'h1);
  endtask

  task report_and_stop;
    $display("counts: %0d mismatches in %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    osc_run = 1'b0;
    req = '0;
    err_total = 0;
    compares = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(PTU_OFS_CTL, 32'hffff_ffff, 32'h0, PTU_RESP_OKAY);
    rd(PTU_OFS_STS, 32'hffff_ffff, 32'h0, PTU_RESP_OKAY);
    rd(PTU_OFS_MASK, 32'hffff_ffff, 32'h0, PTU_RESP_OKAY);
    rd(8'h30, 32'hffff_ffff, 32'h0, PTU_RESP_DECERR);
    wr(8'h30, 32'h1, PTU_RESP_DECERR);
    // Every rate code; timing measured where the period is short enough
    for (int r = 0; r < 8; r++) begin
      cfg = {24'h0, 1'b0, r[2:0], 4'h6};
      wr(PTU_OFS_CTL, 32'h8, PTU_RESP_OKAY);
      wr(PTU_OFS_CTL, cfg, PTU_RESP_OKAY);
      t0 = osc_cnt;
      n0 = nrise;
      if (r < 2) begin
        rd(PTU_OFS_CTL, 32'h7f, cfg, PTU_RESP_OKAY);
      end else begin
        wait_rise(n0);
        s1 = stamp;
        chk("first", {31'h0, (s1 - t0 >= PER[r] / 2 - 3) && (s1 - t0 <= PER[r] / 2 + 3)}, 32'h1);
        rd(PTU_OFS_CTL, 32'hffff_ffff, cfg | 32'h80, PTU_RESP_OKAY);
        wr(PTU_OFS_CTL, cfg | 32'h8, PTU_RESP_OKAY);
        repeat (2) @(negedge clk_sys);
        chk("tick_irq", {31'h0, tick_irq}, 32'h0);
        wait_rise(n0 + 1);
        chk("period", stamp - s1, PER[r]);
      end
    end
    // Stop mode with and without the oscillator kept alive
    wr(PTU_OFS_CTL, 32'h8, PTU_RESP_OKAY);
    wr(PTU_OFS_CTL, 32'h76, PTU_RESP_OKAY);
    stop_mode <= 1'b1;
    repeat (100) @(negedge clk_sys);
    chk("tick_irq", {31'h0, tick_irq}, 32'h0);
    chk("stop_wake", {31'h0, stop_wake}, 32'h0);
    @(posedge clk_sys);
    osc_run <= 1'b1;
    repeat (40) @(negedge clk_sys);
    chk("tick_irq", {31'h0, tick_irq}, 32'h1);
    chk("stop_wake", {31'h0, stop_wake}, 32'h1);
    wr(PTU_OFS_CTL, 32'h7e, PTU_RESP_SLVERR);
    stop_mode <= 1'b0;
    osc_run <= 1'b0;
    wait_mode <= 1'b1;
    rd(PTU_OFS_CTL, 32'hffff_ffff, 32'h0, PTU_RESP_SLVERR);
    chk("tick_irq", {31'h0, tick_irq}, 32'h1);
    wr(PTU_OFS_STS, 32'h1, PTU_RESP_OKAY);
    repeat (40) @(negedge clk_sys);
    rd(PTU_OFS_STS, 32'h3, 32'h3, PTU_RESP_OKAY);
    wait_mode <= 1'b0;
    // Event status, mask and the level interrupt
    wr(PTU_OFS_CTL, 32'h0, PTU_RESP_OKAY);
    repeat (2) @(negedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(PTU_OFS_MASK, 32'h1, PTU_RESP_OKAY);
    repeat (2) @(negedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(PTU_OFS_STS, 32'h3, PTU_RESP_OKAY);
    repeat (2) @(negedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0);
    repeat (200) @(negedge clk_sys);
    rd(PTU_OFS_STS, 32'h3, 32'h0, PTU_RESP_OKAY);
    rd(PTU_OFS_MASK, 32'h3, 32'h1, PTU_RESP_OKAY);
    report_and_stop;
  end
endmodule // tb
